// ==== design/tmc_core.sv ====
/*
 * Timer core: count-up counter, comparators A and P, compare/PWM output
 * pair, capture, single pulse, byte-split register access, AXI4-Lite.
 * Assumes pins reach it already routed by the pin-sharing logic.
 */
`timescale 1ns/1ps
module tmc_core (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [4:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [4:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        ext_clock_pin,
   input  wire logic        capture_in_pin,
   input  wire logic        sub_clock_pin,
   output logic             timer_out_pin,
   output logic             timer_out_inv_pin,
   output logic             compare_a_event,
   output logic             period_event
);
   localparam int W = tmc_pkg::CNT_W;

   tmc_pkg::tmc_state_t s_r;
   tmc_pkg::tmc_state_t s_nxt;

   logic [2:0]   rise;
   logic [2:0]   fall;
   logic         wr_hs;
   logic         rd_hs;
   logic         tick;
   logic         running;
   logic [W-1:0] nxt_cnt;
   logic         match_a;
   logic         match_p;
   logic         cap_ev;
   logic         trig;
   logic         duty_on;
   logic [2:0]   ck;
   logic [1:0]   mode;
   logic [1:0]   io;
   logic [2:0]   rp;

   function automatic logic known_addr(input logic [4:0] a);
      known_addr = (a == tmc_pkg::OFS_CTRL0) || (a == tmc_pkg::OFS_CTRL1)
         || (a == tmc_pkg::OFS_CNT_LO) || (a == tmc_pkg::OFS_CNT_HI)
         || (a == tmc_pkg::OFS_CMPA_LO) || (a == tmc_pkg::OFS_CMPA_HI)
         || (a == tmc_pkg::OFS_CTRL2) || (a == tmc_pkg::OFS_STATUS);
   endfunction

   // Byte view of a 10-bit value, upper unused bits read as zero
   function automatic logic [7:0] hi_byte(input logic [W-1:0] v);
      hi_byte = {6'h00, v[W-1:8]};
   endfunction

   assign ck = s_r.ctrl0[tmc_pkg::CTRL0_CK +: 3];
   assign rp = s_r.ctrl0[tmc_pkg::CTRL0_RP +: 3];
   assign mode = s_r.ctrl1[tmc_pkg::CTRL1_MODE +: 2];
   assign io = s_r.ctrl1[tmc_pkg::CTRL1_IO +: 2];

   // Edges of the filtered pin levels
   assign rise = s_r.filt & ~s_r.filt_d;
   assign fall = ~s_r.filt & s_r.filt_d;

   // One write accepted only with address and data together
   assign wr_hs = s_axi_awvalid & s_axi_wvalid & ~s_r.bvalid;
   assign rd_hs = s_axi_arvalid & ~s_r.rvalid;
   assign s_axi_awready = wr_hs;
   assign s_axi_wready = wr_hs;
   assign s_axi_arready = ~s_r.rvalid;

   always_comb begin
      unique case (ck)
         tmc_pkg::CK_SYS4: tick = &s_r.div[1:0];
         tmc_pkg::CK_SYS: tick = 1'b1;
         tmc_pkg::CK_H16: tick = &s_r.div[3:0];
         tmc_pkg::CK_H64: tick = &s_r.div[5:0];
         tmc_pkg::CK_SUB0,
         tmc_pkg::CK_SUB1: tick = rise[tmc_pkg::PIN_SUB];
         tmc_pkg::CK_EXT_R: tick = rise[tmc_pkg::PIN_EXT];
         tmc_pkg::CK_EXT_F: tick = fall[tmc_pkg::PIN_EXT];
      endcase
   end

   assign running = (s_r.ctrl0[tmc_pkg::CTRL0_ON] | s_r.sp_run)
      & ~s_r.ctrl0[tmc_pkg::CTRL0_PAUSE];
   assign nxt_cnt = s_r.cnt + W'(1);
   // Period on top three bits; code zero means natural overflow
   assign match_p = running & tick & (nxt_cnt[W-1 -: 3] == rp)
      & (nxt_cnt[W-4:0] == '0);
   assign match_a = running & tick & (nxt_cnt == s_r.cmpa);

   always_comb begin
      unique case (s_r.ctrl2[tmc_pkg::CTRL2_EDGE +: 2])
         2'h0: cap_ev = rise[tmc_pkg::PIN_CAP];
         2'h1: cap_ev = fall[tmc_pkg::PIN_CAP];
         default: cap_ev = rise[tmc_pkg::PIN_CAP] | fall[tmc_pkg::PIN_CAP];
      endcase
   end

   // Single pulse starts on the external pin's rising edge
   assign trig = s_r.ctrl2[tmc_pkg::CTRL2_SINGLE] & ~s_r.sp_run
      & ~s_r.ctrl0[tmc_pkg::CTRL0_ON] & rise[tmc_pkg::PIN_EXT];

   // Duty compare: A by default, P's top bits when swapped
   assign duty_on = s_r.ctrl1[tmc_pkg::CTRL1_DPX]
      ? (s_r.cnt[W-1 -: 3] < rp) : (s_r.cnt < s_r.cmpa);

   always_comb begin
      s_nxt = s_r;
      s_nxt.irq_a = 1'b0;
      s_nxt.irq_p = 1'b0;

      // Three stages; level taken once stages two and three agree
      s_nxt.sync1 = {sub_clock_pin, capture_in_pin, ext_clock_pin};
      s_nxt.sync2 = s_r.sync1;
      s_nxt.sync3 = s_r.sync2;
      for (int i = 0; i < 3; i++) begin
         if (s_r.sync2[i] == s_r.sync3[i]) begin
            s_nxt.filt[i] = s_r.sync3[i];
         end
      end
      s_nxt.filt_d = s_r.filt;
      s_nxt.div = s_r.div + 6'h01;
      s_nxt.on_d = s_r.ctrl0[tmc_pkg::CTRL0_ON];

      // Counting and clearing
      if (running & tick) begin
         s_nxt.cnt = nxt_cnt;
         if (s_r.ctrl1[tmc_pkg::CTRL1_CCLR] ? match_a : match_p) begin
            s_nxt.cnt = '0;
         end
      end
      s_nxt.irq_a = match_a;
      s_nxt.irq_p = match_p;

      unique case (mode)
         tmc_pkg::MODE_CMP: begin
            if (match_a) begin
               unique case (io)
                  2'h0: s_nxt.out = s_r.out;
                  2'h1: s_nxt.out = 1'b0;
                  2'h2: s_nxt.out = 1'b1;
                  2'h3: s_nxt.out = ~s_r.out;
               endcase
               if (s_r.sp_run) begin
                  // Pulse ends at the A match
                  s_nxt.sp_run = 1'b0;
                  s_nxt.out = ~s_r.ctrl1[tmc_pkg::CTRL1_OC];
               end
            end
         end
         tmc_pkg::MODE_CAP: begin
            if (cap_ev & running) begin
               s_nxt.cmpa = s_r.cnt;
               s_nxt.irq_a = 1'b1;
            end
         end
         tmc_pkg::MODE_PWM: begin
            unique case (io)
               2'h0: s_nxt.out = ~s_r.ctrl1[tmc_pkg::CTRL1_OC];
               2'h1: s_nxt.out = s_r.ctrl1[tmc_pkg::CTRL1_OC];
               2'h2: s_nxt.out = duty_on ? s_r.ctrl1[tmc_pkg::CTRL1_OC]
                                         : ~s_r.ctrl1[tmc_pkg::CTRL1_OC];
               2'h3: s_nxt.out = s_r.out;
            endcase
         end
         tmc_pkg::MODE_TMR: s_nxt.out = s_r.out;
      endcase

      // Turning on clears the counter and restores initial level
      if (s_r.ctrl0[tmc_pkg::CTRL0_ON] & ~s_r.on_d) begin
         s_nxt.cnt = '0;
         s_nxt.out = s_r.ctrl1[tmc_pkg::CTRL1_OC];
      end
      if (trig) begin
         s_nxt.sp_run = 1'b1;
         s_nxt.cnt = '0;
         s_nxt.out = s_r.ctrl1[tmc_pkg::CTRL1_OC];
      end

      // Pin pair from flops; polarity applied once here
      s_nxt.pin = s_nxt.out ^ s_r.ctrl1[tmc_pkg::CTRL1_POL];

      // Read side; high byte read snapshots the low byte
      if (s_r.rvalid & s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (rd_hs) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = known_addr(s_axi_araddr) ? tmc_pkg::RESP_OK
                                                : tmc_pkg::RESP_SLVERR;
         s_nxt.rdata = 32'h0000_0000;
         unique case (s_axi_araddr)
            tmc_pkg::OFS_CTRL0: s_nxt.rdata[7:0] = s_r.ctrl0;
            tmc_pkg::OFS_CTRL1: s_nxt.rdata[7:0] = s_r.ctrl1;
            tmc_pkg::OFS_CTRL2: s_nxt.rdata[2:0] = s_r.ctrl2;
            tmc_pkg::OFS_STATUS:
               s_nxt.rdata[2:0] = {s_r.sp_run, running, s_r.pin};
            tmc_pkg::OFS_CNT_LO,
            tmc_pkg::OFS_CMPA_LO: s_nxt.rdata[7:0] = s_r.hold;
            tmc_pkg::OFS_CNT_HI: begin
               s_nxt.rdata[7:0] = hi_byte(s_r.cnt);
               s_nxt.hold = s_r.cnt[7:0];
            end
            tmc_pkg::OFS_CMPA_HI: begin
               s_nxt.rdata[7:0] = hi_byte(s_r.cmpa);
               s_nxt.hold = s_r.cmpa[7:0];
            end
            default: s_nxt.rdata = 32'h0000_0000;
         endcase
      end

      // Write side; a buffer write in the same cycle wins over a snapshot
      if (s_r.bvalid & s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (wr_hs) begin
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = known_addr(s_axi_awaddr) ? tmc_pkg::RESP_OK
                                                : tmc_pkg::RESP_SLVERR;
         if (s_axi_wstrb[0]) begin
            unique case (s_axi_awaddr)
               tmc_pkg::OFS_CTRL0: s_nxt.ctrl0 = s_axi_wdata[7:0];
               tmc_pkg::OFS_CTRL1: s_nxt.ctrl1 = s_axi_wdata[7:0];
               tmc_pkg::OFS_CTRL2: s_nxt.ctrl2 = s_axi_wdata[2:0];
               tmc_pkg::OFS_CMPA_LO:
                  s_nxt.hold = s_axi_wdata[7:0];
               tmc_pkg::OFS_CMPA_HI:
                  s_nxt.cmpa = {s_axi_wdata[W-9:0], s_r.hold};
               default: s_nxt.hold = s_nxt.hold;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;
   assign timer_out_pin = s_r.pin;
   assign timer_out_inv_pin = ~s_r.pin;
   assign compare_a_event = s_r.irq_a;
   assign period_event = s_r.irq_p;
endmodule

// ==== design/tmc_pkg.sv ====
/*
 * Shared constants and the state record of the timer core.
 * Assumes an AXI4-Lite master with 32-bit data and 5-bit byte addresses.
 */
package tmc_pkg;
   localparam int CNT_W = 10;
   localparam int ADDR_W = 5;

   // Register byte offsets
   localparam logic [4:0] OFS_CTRL0 = 5'h00;
   localparam logic [4:0] OFS_CTRL1 = 5'h04;
   localparam logic [4:0] OFS_CNT_LO = 5'h08;
   localparam logic [4:0] OFS_CNT_HI = 5'h0c;
   localparam logic [4:0] OFS_CMPA_LO = 5'h10;
   localparam logic [4:0] OFS_CMPA_HI = 5'h14;
   localparam logic [4:0] OFS_CTRL2 = 5'h18;
   localparam logic [4:0] OFS_STATUS = 5'h1c;

   // Field positions
   localparam int CTRL0_PAUSE = 7;
   localparam int CTRL0_CK = 4;
   localparam int CTRL0_ON = 3;
   localparam int CTRL0_RP = 0;
   localparam int CTRL1_MODE = 6;
   localparam int CTRL1_IO = 4;
   localparam int CTRL1_OC = 3;
   localparam int CTRL1_POL = 2;
   localparam int CTRL1_DPX = 1;
   localparam int CTRL1_CCLR = 0;
   localparam int CTRL2_EDGE = 0;
   localparam int CTRL2_SINGLE = 2;

   // Clock select codes
   localparam logic [2:0] CK_SYS4 = 3'h0;
   localparam logic [2:0] CK_SYS = 3'h1;
   localparam logic [2:0] CK_H16 = 3'h2;
   localparam logic [2:0] CK_H64 = 3'h3;
   localparam logic [2:0] CK_SUB0 = 3'h4;
   localparam logic [2:0] CK_SUB1 = 3'h5;
   localparam logic [2:0] CK_EXT_R = 3'h6;
   localparam logic [2:0] CK_EXT_F = 3'h7;

   // Operating modes
   localparam logic [1:0] MODE_CMP = 2'h0;
   localparam logic [1:0] MODE_CAP = 2'h1;
   localparam logic [1:0] MODE_PWM = 2'h2;
   localparam logic [1:0] MODE_TMR = 2'h3;

   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Pin index in the synchroniser vectors
   localparam int PIN_EXT = 0;
   localparam int PIN_CAP = 1;
   localparam int PIN_SUB = 2;

   typedef struct packed {
      logic [2:0]  sync1;
      logic [2:0]  sync2;
      logic [2:0]  sync3;
      logic [2:0]  filt;
      logic [2:0]  filt_d;
      logic [5:0]  div;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] cmpa;
      logic [7:0]  hold;
      logic [7:0]  ctrl0;
      logic [7:0]  ctrl1;
      logic [2:0]  ctrl2;
      logic        on_d;
      logic        sp_run;
      logic        out;
      logic        pin;
      logic        irq_a;
      logic        irq_p;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } tmc_state_t;
endpackage

// ==== tb/tmc_core_sva.sv ====
/*
 * Port checker for the timer core: bus handshakes, output pair, events.
 * Assumes it is bound to tmc_core and sees only its ports.
 */
`timescale 1ns/1ps
module tmc_core_sva (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        timer_out_pin,
   input wire logic        timer_out_inv_pin,
   input wire logic        compare_a_event,
   input wire logic        period_event
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_inv_pair: assert property (timer_out_inv_pin == !timer_out_pin)
      else $error("inverted output differs from primary");
   a_aw_ready: assert property (s_axi_awready ==
      (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
      else $error("awready not tied to paired valids");
   a_w_ready: assert property (s_axi_wready == s_axi_awready)
      else $error("wready differs from awready");
   a_b_answer: assert property (s_axi_awvalid && s_axi_awready
      |=> s_axi_bvalid) else $error("no write response after take");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_r_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("no read data after take");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed while waiting");
   a_ar_ready: assert property (s_axi_arready == !s_axi_rvalid)
      else $error("arready not inverse of rvalid");
   a_a_pulse: assert property (compare_a_event |=> !compare_a_event)
      else $error("compare a event longer than one cycle");
   a_p_pulse: assert property (period_event |=> !period_event[*8])
      else $error("period events too close");

   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_a_event: cover property (compare_a_event);
   c_p_event: cover property (period_event);
endmodule

bind tmc_core tmc_core_sva chk (.clk, .rstn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .timer_out_pin, .timer_out_inv_pin, .compare_a_event,
   .period_event);

// ==== tb/tmc_core_test.sv ====
/*
 * Self-checking bench for the timer core, driving AXI4-Lite and pins.
 * Assumes tmc_core and tmc_pkg are compiled first; clock is 200 MHz.
 */
`timescale 1ns/1ps
module tmc_core_test;
   logic        clk, rstn, ext_pin, cap_pin, sub_pin, out_pin, inv_pin;
   logic [4:0]  awaddr, araddr;
   logic [31:0] wdata, rd, rv;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rs;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, a_ev, p_ev;
   logic [9:0]  v;
   logic [2:0]  rp;
   int          fails, comparisons, c;

   // Pins taken as already routed to the timer by the bench
   tmc_core uut (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .ext_clock_pin(ext_pin),
      .capture_in_pin(cap_pin), .sub_clock_pin(sub_pin),
      .timer_out_pin(out_pin), .timer_out_inv_pin(inv_pin),
      .compare_a_event(a_ev), .period_event(p_ev));

   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Ready is looked at on the falling edge, so the taking edge is clean
   task automatic wr(logic [4:0] a, logic [7:0] d, logic [1:0] e = 2'h0);
      int n;
      n = 0;
      // Start on a rising edge, whatever edge the caller left on
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(negedge clk); while (!awready && ++n < 50);
      @(posedge clk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(negedge clk); while (!bvalid && ++n < 100);
      chk("bresp", e, bresp);
      @(posedge clk);
      bready <= 1'b0;
   endtask

   task automatic rdr(logic [4:0] a);
      int n;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge clk); while (!arready && ++n < 50);
      @(posedge clk);
      arvalid <= 1'b0;
      do @(negedge clk); while (!rvalid && ++n < 100);
      rv = rd;
      rs = rresp;
      @(posedge clk);
      rready <= 1'b0;
   endtask

   task automatic wait_ev(bit p);
      c = 0;
      do begin
         @(negedge clk);
         c++;
      end while (!(p ? p_ev : a_ev) && c < 4000);
      chk("event seen", 1, c < 4000);
   endtask

   function automatic int edges(bit fall, logic s, int n);
      return (s ^ fall) ? n / 2 : (n + 1) / 2;
   endfunction

   task automatic ext_run(bit fall, int n);
      logic s;
      s = ext_pin;
      wr(tmc_pkg::OFS_CTRL1, 8'hc0);
      wr(tmc_pkg::OFS_CTRL0, 8'h00);
      wr(tmc_pkg::OFS_CTRL0, fall ? 8'h78 : 8'h68);
      repeat (n) begin
         repeat (8) @(posedge clk);
         ext_pin <= ~ext_pin;
      end
      // Pin path has several flops of delay before the count moves
      repeat (12) @(posedge clk);
      rdr(tmc_pkg::OFS_CNT_HI);
      v[9:8] = rv[1:0];
      rdr(tmc_pkg::OFS_CNT_LO);
      chk("counter", edges(fall, s, n), {v[9:8], rv[7:0]});
   endtask

   task automatic stop_test;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      #(100000 * 5);
      fails++;
      stop_test();
   end

   initial begin
      {rstn, ext_pin, cap_pin, sub_pin, awvalid, wvalid, bready} = '0;
      {arvalid, rready, awaddr, araddr, wdata} = '0;
      wstrb = 4'h1;
      fails = 0;
      comparisons = 0;
      void'($urandom(32'h8f18));
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      chk("out reset", 2'b01, {out_pin, inv_pin});
      v = 10'($urandom());
      wr(tmc_pkg::OFS_CMPA_LO, v[7:0]);
      wr(tmc_pkg::OFS_CMPA_HI, {6'h0, v[9:8]});
      rdr(tmc_pkg::OFS_CMPA_HI);
      chk("cmpa hi", v[9:8], rv);
      rdr(tmc_pkg::OFS_CMPA_LO);
      chk("cmpa lo", v[7:0], rv);
      wr(tmc_pkg::OFS_CMPA_LO, ~v[7:0]);
      rdr(tmc_pkg::OFS_CMPA_HI);
      rdr(tmc_pkg::OFS_CMPA_LO);
      chk("cmpa lo kept", v[7:0], rv);
      wr(5'h02, 8'h55, tmc_pkg::RESP_SLVERR);
      rdr(5'h02);
      chk("rresp", tmc_pkg::RESP_SLVERR, rs);
      $display("test buffer done");
      ext_run(1'b0, $urandom_range(40, 3));
      ext_run(1'b1, $urandom_range(40, 3));
      $display("test external clock done");
      for (int io = 1; io < 4; io++) begin
         wr(tmc_pkg::OFS_CTRL0, 8'h00);
         wr(tmc_pkg::OFS_CMPA_LO, 8'h20);
         wr(tmc_pkg::OFS_CMPA_HI, 8'h00);
         wr(tmc_pkg::OFS_CTRL1, {2'b00, io[1:0], io == 1, 3'b001});
         wr(tmc_pkg::OFS_CTRL0, 8'h18);
         repeat (2) @(negedge clk);
         chk("out start", io == 1, out_pin);
         wait_ev(1'b0);
         repeat (2) @(negedge clk);
         chk("out first", io != 1, out_pin);
         wait_ev(1'b0);
         repeat (2) @(negedge clk);
         chk("out second", io == 2, out_pin);
      end
      $display("test compare output done");
      // PWM active level 1 while count is below compare A
      wr(tmc_pkg::OFS_CTRL0, 8'h00);
      wr(tmc_pkg::OFS_CTRL1, 8'ha8);
      wr(tmc_pkg::OFS_CTRL0, 8'h18);
      repeat (2) @(negedge clk);
      chk("pwm active", 1, out_pin);
      wait_ev(1'b0);
      repeat (2) @(negedge clk);
      chk("pwm inactive", 0, out_pin);
      chk("pwm inverse", 1, inv_pin);
      $display("test pwm done");
      rp = 3'($urandom_range(3, 1));
      wr(tmc_pkg::OFS_CTRL0, 8'h00);
      wr(tmc_pkg::OFS_CMPA_HI, 8'h03);
      wr(tmc_pkg::OFS_CTRL1, 8'h00);
      wr(tmc_pkg::OFS_CTRL0, {5'b00011, rp});
      wait_ev(1'b1);
      wait_ev(1'b1);
      chk("period", 128 * rp, c);
      $display("test period done");
      stop_test();
   end
endmodule
